/* verif/cdi_far_model.sv */
// far-side model: dsp user lines and peripheral interrupt sources
// assumes the bench commands levels; lines move only after a rising edge
////////////////////////////////////////////////////////////
module cdi_far_model (
  input  wire logic        core_clk_i,
  input  wire logic [4:0]  line_cmd_i,
  input  wire logic [29:1] src_a_cmd_i,
  input  wire logic [1:0]  src_b_cmd_i,
  input  wire logic        radio_cmd_i,
  input  wire logic [3:0]  fifo_cmd_i,
  output logic      [4:0]  dsp_line_o,
  output logic      [29:1] src_a_o,
  output logic      [1:0]  src_b_o,
  output logic             radio_set_o,
  output logic      [3:0]  fifo_irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // sources are levels held by their owners, except the radio set, which the bench pulses for one cycle
  always @(posedge core_clk_i) begin
    dsp_line_o  <= line_cmd_i;
    src_a_o     <= src_a_cmd_i;
    src_b_o     <= src_b_cmd_i;
    radio_set_o <= radio_cmd_i;
    fifo_irq_o  <= fifo_cmd_i;
  end
endmodule

/* verif/test_cdi_irq_unit.sv */
// bench for the cpu/dsp interrupt and wake-up unit
// assumes one clock; bench is the only ahb master
////////////////////////////////////////////////////////////
module test_cdi_irq_unit;
  timeunit 1ns;
  timeprecision 1ps;
  logic               clk, nrst, hwrite, hrdy, hresp, wexec, radio_cmd, radio_set;
  logic               cpu_irq, radio_irq, clk_en, irq;
  logic        [1:0]  htrans, info, src_b, src_b_cmd;
  logic        [31:0] haddr, hwdata;
  logic        [4:0]  line, line_cmd;
  logic        [29:1] src_a, src_a_cmd;
  logic        [3:0]  fifo, fifo_cmd, fifo_out;
  cdi_pkg::cdi_word_t hrdata, rd;
  int                 failures, n_checks;

  cdi_irq_unit dut (.core_clk_i(clk), .nrst_i(nrst), .hsel_i(1'b1), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp),
    .dsp_user_line_i(line), .wake_src_a_i(src_a), .wake_src_b_i(src_b),
    .radio_bb_set_i(radio_set), .fifo_irq_i(fifo), .wait_exec_i(wexec),
    .cpu_to_dsp_irq_bit_o(cpu_irq), .cpu_info_o(info), .dsp_fifo_irq_o(fifo_out),
    .radio_bb_irq_o(radio_irq), .cpu_clk_en_o(clk_en), .irq_o(irq));
  cdi_far_model far (.core_clk_i(clk), .line_cmd_i(line_cmd), .src_a_cmd_i(src_a_cmd),
    .src_b_cmd_i(src_b_cmd), .radio_cmd_i(radio_cmd), .fifo_cmd_i(fifo_cmd),
    .dsp_line_o(line), .src_a_o(src_a), .src_b_o(src_b), .radio_set_o(radio_set),
    .fifo_irq_o(fifo));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(input cdi_pkg::cdi_word_t got, input cdi_pkg::cdi_word_t exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: saw %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // a hung slave counts as a mismatch and ends the run
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hrdy !== 1'b1 && n < 20);
    if (hrdy !== 1'b1) begin
      failures++;
      complete_run();
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input cdi_pkg::cdi_word_t wd);
    htrans <= 2'h2;
    haddr  <= {24'h00_0000, a};
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input cdi_pkg::cdi_word_t d);
    bus(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [7:0] a, input cdi_pkg::cdi_word_t exp);
    bus(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_reset();
    check({31'h0, clk_en}, 32'h1);
    rdchk(8'h28, 32'h0);
    rdchk(8'h2C, 32'h0);
    rdchk(8'h30, 32'h0);
    rdchk(8'h34, 32'h0);
    rdchk(8'h40, 32'h0);
    rdchk(8'h44, 32'h0);
    rdchk(8'h50, 32'h5);
    rdchk(8'h60, 32'h0);
    check({31'h0, hresp}, 32'h0);
  endtask
  task automatic t_out();
    wr(8'h28, 32'hFFFF_FFFF);
    rdchk(8'h28, 32'h1);
    check({31'h0, cpu_irq}, 32'h1);
    wr(8'h28, 32'h0);
    tick(1);
    check({31'h0, cpu_irq}, 32'h0);
    wr(8'h34, 32'hFFFF_FFFF);
    rdchk(8'h34, 32'h3);
    wr(8'h34, 32'h2);
    tick(1);
    check({30'h0, info}, 32'h2);
  endtask
  task automatic t_pend();
    line_cmd <= 5'h04;
    tick(6);
    rdchk(8'h2C, 32'h4);
    rdchk(8'h30, 32'h4);
    wr(8'h38, 32'h4);
    tick(2);
    check({31'h0, irq}, 32'h1);
    wr(8'h30, 32'h0);
    rdchk(8'h30, 32'h4);
    wr(8'h30, 32'h4);
    rdchk(8'h30, 32'h0);
    check({31'h0, irq}, 32'h0);
    line_cmd <= 5'h11;
    tick(6);
    rdchk(8'h30, 32'h11);
    wr(8'h30, 32'h1F);
    line_cmd <= 5'h00;
  endtask
  task automatic t_wake();
    wr(8'h40, 32'h3FFF_FFFE);
    rdchk(8'h40, 32'h3FFF_FFFE);
    wr(8'h44, 32'hFFFF_FFFF);
    rdchk(8'h44, 32'h8000_083F);
    wr(8'h40, 32'h0);
    wr(8'h44, 32'h0);
  endtask
  task automatic t_fifo();
    fifo_cmd <= 4'hF;
    tick(4);
    for (int i = 0; i < 4; i++) begin
      wr(8'h50, 32'h1 << i);
      tick(2);
      check({28'h0, fifo_out}, 32'h1 << i);
    end
    fifo_cmd <= 4'h0;
  endtask
  task automatic t_radio();
    radio_cmd <= 1'b1;
    tick(1);
    radio_cmd <= 1'b0;
    tick(5);
    check({31'h0, radio_irq}, 32'h1);
    rdchk(8'h40, 32'h1);
    wr(8'h40, 32'h0);
    tick(1);
    check({31'h0, radio_irq}, 32'h0);
  endtask
  task automatic t_gate();
    for (int k = 0; k < 3; k++) begin
      wr(8'h44, (k == 2) ? 32'h8000_0001 : 32'h8000_0800);
      wr(8'h40, (k == 1) ? 32'h2000_0000 : 32'h0);
      wexec <= 1'b1;
      tick(1);
      wexec <= 1'b0;
      tick(2);
      check({31'h0, clk_en}, 32'h0);
      if (k == 1) src_a_cmd[29] <= 1'b1;
      else if (k == 2) line_cmd[0] <= 1'b1;
      else src_b_cmd[1] <= 1'b1;
      tick(6);
      check({31'h0, clk_en}, 32'h1);
      src_a_cmd <= '0;
      src_b_cmd <= '0;
      line_cmd  <= '0;
      tick(4);
    end
    wr(8'h44, 32'h0);
    wexec <= 1'b1;
    tick(1);
    wexec <= 1'b0;
    tick(3);
    check({31'h0, clk_en}, 32'h1);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    {nrst, hwrite, wexec, radio_cmd, htrans, haddr, hwdata} = '0;
    {line_cmd, src_a_cmd, src_b_cmd, fifo_cmd} = '0;
    failures = 0;
    n_checks = 0;
    tick(12);
    nrst <= 1'b1;
    tick(1);
    t_reset();
    t_out();
    t_pend();
    t_wake();
    t_fifo();
    t_radio();
    t_gate();
    complete_run();
  end
endmodule

/* verilog/cdi_irq_unit.sv */
// cpu/dsp interrupt exchange and cpu wake-up unit, ahb-lite slave
// assumes one clock, synchronous active-low reset, one ahb master
`include "cdi_params.svh"

////////////////////////////////////////////////////////////////////////////////
module cdi_irq_unit #(
  parameter int unsigned USER_LINES = 5,
  parameter int unsigned FIFO_IRQS  = 4
) (
  input  wire logic                  core_clk_i,
  input  wire logic                  nrst_i,
  input  wire logic                  hsel_i,
  input  wire logic [31:0]           haddr_i,
  input  wire logic [1:0]            htrans_i,
  input  wire logic                  hwrite_i,
  input  wire logic [2:0]            hsize_i,
  input  wire logic [31:0]           hwdata_i,
  input  wire logic                  hready_i,
  output logic      [31:0]           hrdata_o,
  output logic                       hreadyout_o,
  output logic                       hresp_o,
  input  wire logic [USER_LINES-1:0] dsp_user_line_i,
  input  wire logic [29:1]           wake_src_a_i,
  input  wire logic [1:0]            wake_src_b_i,
  input  wire logic                  radio_bb_set_i,
  input  wire logic [FIFO_IRQS-1:0]  fifo_irq_i,
  input  wire logic                  wait_exec_i,
  output logic                       cpu_to_dsp_irq_bit_o,
  output logic [1:0]                 cpu_info_o,
  output logic [FIFO_IRQS-1:0]       dsp_fifo_irq_o,
  output logic                       radio_bb_irq_o,
  output logic                       cpu_clk_en_o,
  output logic                       irq_o
);

  localparam int unsigned SYNC_W = FIFO_IRQS + 1 + 2 + 29 + USER_LINES;

  cdi_pkg::cdi_phase_t     ph_q;
  cdi_pkg::cdi_phase_t     ph_d;
  logic [7:0]              addr_q;
  logic [31:0]             hrdata_q;
  logic                    hready_q;
  logic                    hresp_q;
  logic [SYNC_W-1:0]       meta_q;
  logic [SYNC_W-1:0]       sync_q;
  logic [USER_LINES-1:0]   user_prev_q;
  logic [USER_LINES-1:0]   user_s;
  logic                    req_q;
  logic [1:0]              info_q;
  logic [USER_LINES-1:0]   pend_q;
  logic [USER_LINES-1:0]   pend_d;
  logic [USER_LINES-1:0]   mask_q;
  cdi_pkg::cdi_word_t      wake_a_q;
  cdi_pkg::cdi_word_t      wake_a_d;
  cdi_pkg::cdi_word_t      wake_b_q;
  logic [FIFO_IRQS-1:0]    fifo_en_q;
  logic [FIFO_IRQS-1:0]    fifo_out_q;
  logic                    clk_run_q;
  logic                    clk_run_d;
  logic                    irq_q;

  ////////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave: writes take no wait state, reads one
  // hsize is ignored; only whole-word transfers are expected

  wire accept   = hsel_i & htrans_i[1] & hready_i;
  wire wr_ph    = (ph_q == cdi_pkg::PH_WR);
  wire rd_ph    = (ph_q == cdi_pkg::PH_RD);
  wire wr_req   = wr_ph & (addr_q == `CDI_OFF_REQ_INT);
  wire wr_pend  = wr_ph & (addr_q == `CDI_OFF_PEND);
  wire wr_info  = wr_ph & (addr_q == `CDI_OFF_INFO);
  wire wr_mask  = wr_ph & (addr_q == `CDI_OFF_MASK);
  wire wr_wa    = wr_ph & (addr_q == `CDI_OFF_WAKE_A);
  wire wr_wb    = wr_ph & (addr_q == `CDI_OFF_WAKE_B);
  wire wr_fifo  = wr_ph & (addr_q == `CDI_OFF_FIFO_EN);

  assign ph_d = !accept  ? cdi_pkg::PH_IDLE :
                hwrite_i ? cdi_pkg::PH_WR : cdi_pkg::PH_RD;

  // the read word is picked a cycle late so a write just before is seen
  wire [31:0] rd_word =
    (addr_q == `CDI_OFF_REQ_INT) ? {31'h0000_0000, req_q} :
    (addr_q == `CDI_OFF_SAMPLE)  ? {{(32-USER_LINES){1'b0}}, user_s} :
    (addr_q == `CDI_OFF_PEND)    ? {{(32-USER_LINES){1'b0}}, pend_q} :
    (addr_q == `CDI_OFF_INFO)    ? {30'h0000_0000, info_q} :
    (addr_q == `CDI_OFF_MASK)    ? {{(32-USER_LINES){1'b0}}, mask_q} :
    (addr_q == `CDI_OFF_WAKE_A)  ? wake_a_q :
    (addr_q == `CDI_OFF_WAKE_B)  ? wake_b_q :
    (addr_q == `CDI_OFF_FIFO_EN) ? {{(32-FIFO_IRQS){1'b0}}, fifo_en_q} :
    32'h0000_0000;

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      ph_q     <= cdi_pkg::PH_IDLE;
      addr_q   <= 8'h00;
      hrdata_q <= 32'h0000_0000;
      hready_q <= 1'b1;
      hresp_q  <= 1'b0;
    end else begin
      ph_q     <= ph_d;
      addr_q   <= accept ? haddr_i[7:0] : addr_q;
      hrdata_q <= rd_ph ? rd_word : hrdata_q;
      hready_q <= !(accept & !hwrite_i);
      hresp_q  <= 1'b0;
    end
  end

  assign hrdata_o    = hrdata_q;
  assign hreadyout_o = hready_q;
  assign hresp_o     = hresp_q;

  ////////////////////////////////////////////////////////////////////////////////
  // two-stage synchronisers for every pin-side input

  wire [SYNC_W-1:0] async_in = {fifo_irq_i, radio_bb_set_i, wake_src_b_i,
                                wake_src_a_i, dsp_user_line_i};

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign user_s = sync_q[USER_LINES-1:0];
  wire [29:1]           src_a_s  = sync_q[USER_LINES+28:USER_LINES];
  wire [1:0]            src_b_s  = sync_q[USER_LINES+30:USER_LINES+29];
  wire                  radio_s  = sync_q[USER_LINES+31];
  wire [FIFO_IRQS-1:0]  fifo_s   = sync_q[SYNC_W-1:USER_LINES+32];

  ////////////////////////////////////////////////////////////////////////////////
  // dsp request, info and line pending flags

  wire [USER_LINES-1:0] rise = user_s & ~user_prev_q;

  // a rising edge in the clearing cycle survives the clear
  assign pend_d = (pend_q & ~(wr_pend ? hwdata_i[USER_LINES-1:0] : '0))
                  | rise;

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      user_prev_q <= '0;
      req_q       <= 1'b0;
      info_q      <= 2'h0;
      pend_q      <= '0;
      mask_q      <= '0;
    end else begin
      user_prev_q <= user_s;
      req_q       <= wr_req ? hwdata_i[`CDI_B_DSP_IRQ] : req_q;
      info_q      <= wr_info ? hwdata_i[1:0] : info_q;
      pend_q      <= pend_d;
      mask_q      <= wr_mask ? hwdata_i[USER_LINES-1:0] : mask_q;
    end
  end

  assign cpu_to_dsp_irq_bit_o = req_q;
  assign cpu_info_o           = info_q;

  ////////////////////////////////////////////////////////////////////////////////
  // wake enables; bit 0 of the first is the radio request bit

  // the baseband's set beats a software write of zero in the same cycle
  assign wake_a_d = ((wr_wa ? hwdata_i : wake_a_q) & `CDI_WA_MASK)
                    | {31'h0000_0000, radio_s};

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      wake_a_q  <= `CDI_RST_WORD;
      wake_b_q  <= `CDI_RST_WORD;
      fifo_en_q <= `CDI_RST_FIFO_EN;
    end else begin
      wake_a_q  <= wake_a_d;
      wake_b_q  <= wr_wb ? (hwdata_i & `CDI_WB_MASK) : wake_b_q;
      fifo_en_q <= wr_fifo ? hwdata_i[FIFO_IRQS-1:0] : fifo_en_q;
    end
  end

  wire gate_on_wait = wake_b_q[`CDI_B_GATE];
  wire hit_a  = |(wake_a_q[29:1] & src_a_s);
  wire hit_b  = (wake_b_q[`CDI_B_SPI3] & src_b_s[1])
              | (wake_b_q[`CDI_B_IR] & src_b_s[0]);
  wire hit_u  = |(wake_b_q[USER_LINES-1:0] & user_s);
  wire wake_hit = hit_a | hit_b | hit_u | wake_a_q[`CDI_B_RADIO];

  ////////////////////////////////////////////////////////////////////////////////
  // cpu clock gate; a wake already present keeps the clock running

  assign clk_run_d = wake_hit ? 1'b1 :
                     (wait_exec_i & gate_on_wait) ? 1'b0 :
                     clk_run_q;

  ////////////////////////////////////////////////////////////////////////////////
  // fifo interrupt gating and the cpu-side interrupt output

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      clk_run_q  <= 1'b1;
      fifo_out_q <= '0;
      irq_q      <= 1'b0;
    end else begin
      clk_run_q  <= clk_run_d;
      fifo_out_q <= fifo_s & fifo_en_q;
      irq_q      <= |(pend_q & mask_q);
    end
  end

  assign cpu_clk_en_o   = clk_run_q;
  assign dsp_fifo_irq_o = fifo_out_q;
  assign radio_bb_irq_o = wake_a_q[`CDI_B_RADIO];
  assign irq_o          = irq_q;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);

  chk_dsp_req_write:
    assert property (wr_req |=> cpu_to_dsp_irq_bit_o == $past(hwdata_i[0]))
    else $error("dsp request bit does not follow write");

  chk_line_sample:
    assert property ((rd_ph && addr_q == `CDI_OFF_SAMPLE)
                     |=> hrdata_o == {{(32-USER_LINES){1'b0}}, $past(user_s)})
    else $error("sampled lines read wrong");

  chk_pend_rise:
    assert property ((|rise) |=> (pend_q & $past(rise)) == $past(rise))
    else $error("rising edge did not set pending");

  chk_pend_clear:
    assert property ((wr_pend && rise == '0)
                     |=> pend_q == ($past(pend_q) & ~$past(hwdata_i[USER_LINES-1:0])))
    else $error("pending clear wrong");

  chk_pend_hold:
    assert property (!wr_pend |=> (pend_q & $past(pend_q)) == $past(pend_q))
    else $error("pending flag lost without write");

  chk_info_write:
    assert property (wr_info |=> cpu_info_o == $past(hwdata_i[1:0]))
    else $error("info bits do not follow write");

  chk_radio_set:
    assert property (radio_s |=> radio_bb_irq_o [*1])
    else $error("radio set lost");

  chk_gate_stop:
    assert property ((wait_exec_i && gate_on_wait && !wake_hit) |=> !cpu_clk_en_o)
    else $error("cpu clock not stopped after wait");

  chk_gate_keep:
    assert property ((cpu_clk_en_o && !gate_on_wait) |=> cpu_clk_en_o)
    else $error("cpu clock stopped while gating disabled");

  chk_wake_restart:
    assert property ((!cpu_clk_en_o && wake_hit) |=> cpu_clk_en_o)
    else $error("cpu clock not restarted by wake source");

  chk_wake_enable:
    assert property ((wake_a_q[`CDI_DMA_HI] && src_a_s[`CDI_DMA_HI]) |-> wake_hit)
    else $error("enabled dma wake ignored");

  chk_fifo_gate:
    assert property (1'b1 |=> dsp_fifo_irq_o == $past(fifo_s & fifo_en_q))
    else $error("fifo interrupt gating wrong");

  chk_read_wait:
    assert property ((accept && !hwrite_i) |=> !hreadyout_o ##1 hreadyout_o)
    else $error("read wait state wrong");

  chk_irq_level:
    assert property ($rose(irq_o) |-> $past(|(pend_q & mask_q)))
    else $error("interrupt raised without unmasked pending");

  chk_req_hold:
    assert property (!wr_req |=> $stable(cpu_to_dsp_irq_bit_o))
    else $error("dsp request bit changed without write");

  chk_info_hold:
    assert property (!wr_info |=> $stable(cpu_info_o))
    else $error("info bits changed without write");

  // reset values are checked with the default disable switched off
  chk_info_reset:
    assert property (disable iff (1'h0) !nrst_i
                     |=> (cpu_info_o == 2'h0 && !cpu_to_dsp_irq_bit_o))
    else $error("dsp outputs not cleared by reset");

  chk_wake_reset:
    assert property (disable iff (1'h0) !nrst_i
                     |=> (wake_a_q == 32'h0000_0000 && wake_b_q == 32'h0000_0000))
    else $error("wake enables not cleared by reset");

  chk_tx_reset:
    assert property (disable iff (1'h0) !nrst_i |=> !fifo_en_q[3])
    else $error("audio tx fifo enable reset wrong");

  chk_dac_reset:
    assert property (disable iff (1'h0) !nrst_i |=> fifo_en_q[2])
    else $error("dac fifo enable reset wrong");

  chk_rx2_reset:
    assert property (disable iff (1'h0) !nrst_i |=> !fifo_en_q[1])
    else $error("audio rx2 fifo enable reset wrong");

  chk_adc_reset:
    assert property (disable iff (1'h0) !nrst_i |=> fifo_en_q[0])
    else $error("adc fifo enable reset wrong");

  chk_fifo_write:
    assert property (wr_fifo |=> fifo_en_q == $past(hwdata_i[FIFO_IRQS-1:0]))
    else $error("fifo enables do not follow write");

  chk_dac_gate:
    assert property ((fifo_s[2] && !fifo_en_q[2]) |=> !dsp_fifo_irq_o[2])
    else $error("disabled dac fifo interrupt passed");

  chk_rx2_gate:
    assert property (!fifo_en_q[1] |=> !dsp_fifo_irq_o[1])
    else $error("disabled audio rx2 fifo interrupt passed");

  chk_adc_gate:
    assert property ((fifo_s[0] && fifo_en_q[0]) |=> dsp_fifo_irq_o[0])
    else $error("enabled adc fifo interrupt blocked");

  chk_wake_a_write:
    assert property ((wr_wa && !radio_s) |=> wake_a_q == ($past(hwdata_i) & `CDI_WA_MASK))
    else $error("first wake register does not follow write");

  chk_wake_a_hold:
    assert property ((!wr_wa && !radio_s) |=> wake_a_q == $past(wake_a_q))
    else $error("first wake register changed without write");

  chk_wake_b_write:
    assert property (wr_wb |=> wake_b_q == ($past(hwdata_i) & `CDI_WB_MASK))
    else $error("second wake register does not follow write");

  chk_wake_b_hold:
    assert property (!wr_wb |=> $stable(wake_b_q))
    else $error("second wake register changed without write");

  chk_spi3_wake:
    assert property ((wake_b_q[`CDI_B_SPI3] && src_b_s[1]) |-> wake_hit)
    else $error("enabled third spi wake ignored");

  chk_user_wake:
    assert property ((wake_b_q[0] && user_s[0]) |-> wake_hit)
    else $error("enabled dsp line wake ignored");

  chk_radio_clear:
    assert property ((wr_wa && !hwdata_i[`CDI_B_RADIO] && !radio_s) |=> !radio_bb_irq_o)
    else $error("radio bit not cleared by software");

  chk_gate_hold:
    assert property ((!cpu_clk_en_o && !wake_hit) |=> !cpu_clk_en_o)
    else $error("cpu clock restarted without wake source");

  // writes never stall the bus
  chk_write_nowait:
    assert property ((accept && hwrite_i) |=> hreadyout_o)
    else $error("write inserted a wait state");

endmodule

/* verilog/cdi_params.svh */
// constants of the cpu/dsp interrupt and wake-up unit
// assumes byte offsets within one 256-byte register window
`ifndef CDI_PARAMS_SVH
`define CDI_PARAMS_SVH
`define CDI_OFF_REQ_INT 8'h28
`define CDI_OFF_SAMPLE  8'h2C
`define CDI_OFF_PEND    8'h30
`define CDI_OFF_INFO    8'h34
`define CDI_OFF_MASK    8'h38
`define CDI_OFF_WAKE_A  8'h40
`define CDI_OFF_WAKE_B  8'h44
`define CDI_OFF_FIFO_EN 8'h50
`define CDI_B_DSP_IRQ   0
`define CDI_B_RADIO     0
`define CDI_B_GATE      31
`define CDI_B_SPI3      11
`define CDI_B_IR        5
`define CDI_DMA_HI      29
`define CDI_DMA_LO      22
`define CDI_WA_MASK     32'h3FFF_FFFF
`define CDI_WB_MASK     32'h8000_083F
`define CDI_RST_WORD    32'h0000_0000
`define CDI_RST_FIFO_EN 4'h5
`define CDI_SYNC_LEN    2
`endif

/* verilog/cdi_pkg.sv */
// types of the cpu/dsp interrupt and wake-up unit
// assumes nothing beyond a sv compiler
package cdi_pkg;
  typedef logic [31:0] cdi_word_t;
  typedef enum logic [2:0] {
    PH_IDLE = 3'h1,
    PH_WR   = 3'h2,
    PH_RD   = 3'h4
  } cdi_phase_t;
endpackage
